//--- sfb_flash_seq.sv
// serial flash buffer, program and erase command sequencer
`timescale 1ns/100ps
`include "sfb_params.svh"

module sfb_flash_seq #(
  parameter int unsigned ERASE_PROG_CYC =
    (`SFB_T_ERASE_PROG_US * 1000) / `SFB_CLK_PERIOD_NS,
  parameter int unsigned PROG_CYC =
    (`SFB_T_PROG_US * 1000) / `SFB_CLK_PERIOD_NS,
  parameter int unsigned PAGE_ERASE_CYC =
    (`SFB_T_PAGE_ERASE_US * 1000) / `SFB_CLK_PERIOD_NS,
  parameter int unsigned BLOCK_ERASE_CYC =
    (`SFB_T_BLOCK_ERASE_US * 1000) / `SFB_CLK_PERIOD_NS
) (
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // serial link
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so_q,
  output logic            so_oe_q,
  // page size strap, high for 256-byte pages
  input  wire logic       page_256,
  // main array port
  output logic            arr_rd_q,
  output logic            arr_wr_q,
  output logic            arr_erase_q,
  output logic [9:0]      arr_page_q,
  output logic [8:0]      arr_col_q,
  output logic [7:0]      arr_wdata_q,
  input  wire logic [7:0] arr_rdata,
  // status
  output logic            busy_q
);

  // address decode for both page sizes
  function automatic logic [9:0] page_of(input logic [23:0] a,
                                         input logic b256);
    return b256 ? a[17:8] : a[18:9];
  endfunction

  function automatic logic [8:0] ofs_of(input logic [23:0] a,
                                        input logic b256);
    return b256 ? {1'b0, a[7:0]} : a[8:0];
  endfunction

  function automatic logic [8:0] ofs_last(input logic b256);
    return b256 ? `SFB_LAST_256 : `SFB_LAST_264;
  endfunction

  function automatic logic [8:0] ofs_next(input logic [8:0] o,
                                          input logic b256);
    return (o == ofs_last(b256)) ? 9'h000 : o + 9'h001;
  endfunction

  // ---------------- link domain ----------------
  logic       link_rst;
  logic [2:0] bit_cnt_q;
  logic [6:0] sh_q;
  logic [7:0] rx_byte_q;
  logic       rx_tgl_q;
  logic       on1_q;
  logic       on2_q;
  logic [6:0] tx_sh_q;
  logic [7:0] tx_byte_q;
  logic       tx_on_q;

  assign link_rst = rst | cs_n;

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 3'h0;
      sh_q      <= 7'h00;
      on1_q     <= 1'b0;
      on2_q     <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sh_q      <= {sh_q[5:0], si};
      on1_q     <= tx_on_q;
      on2_q     <= on1_q;
    end
  end

  // completed byte, held for a whole byte time
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rx_byte_q <= 8'h00;
      rx_tgl_q  <= 1'b0;
    end else if (!cs_n && bit_cnt_q == 3'h7) begin
      rx_byte_q <= {sh_q, si};
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  // output floats until a read drives it
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
      tx_sh_q <= 7'h00;
    end else if (bit_cnt_q == 3'h0) begin
      so_oe_q <= on2_q;
      so_q    <= on2_q & tx_byte_q[7];
      tx_sh_q <= tx_byte_q[6:0];
    end else begin
      so_q    <= tx_sh_q[6];
      tx_sh_q <= {tx_sh_q[5:0], 1'b0};
    end
  end

  // ---------------- system domain ----------------
  logic                t1_q, t2_q, t3_q;
  logic                c1_q, c2_q, c3_q;
  logic                p1_q, p256_q;
  logic                ev;
  logic                cs_rise;
  sfb_pkg::sfb_cmd_e   cmd_q;
  sfb_pkg::sfb_cmd_e   cmd_dec;
  sfb_pkg::sfb_state_e state_q;
  logic [3:0]          idx_q;
  logic [15:0]         addr_q;
  logic [23:0]         addr_full;
  logic [9:0]          page_q;
  logic [8:0]          ptr_q;
  logic [8:0]          ptr_now;
  logic                is_rd;
  logic                is_pg;
  logic [3:0]          hdr_len;
  logic                do_fetch;
  logic                do_bwr;
  logic                pend1_q;
  logic                pend2_q;
  logic                is_op;
  logic                start;
  logic [9:0]          op_page_q;
  sfb_pkg::sfb_cmd_e   op_q;
  logic [8:0]          cnt_q;
  logic [31:0]         tmr_q;
  logic [31:0]         tmr_load;
  logic [2:0]          erase_last;
  logic                ram_we;
  logic [8:0]          ram_addr;
  logic [7:0]          ram_rdata;

  // two-flop crossings of link signals and strap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {t1_q, t2_q, t3_q} <= 3'b000;
      {c1_q, c2_q, c3_q} <= 3'b111;
      {p1_q, p256_q}     <= 2'b00;
    end else begin
      {t1_q, t2_q, t3_q} <= {rx_tgl_q, t1_q, t2_q};
      {c1_q, c2_q, c3_q} <= {cs_n, c1_q, c2_q};
      {p1_q, p256_q}     <= {page_256, p1_q};
    end
  end

  assign ev      = t2_q ^ t3_q;
  assign cs_rise = c2_q & ~c3_q;

  assign cmd_dec =
    (rx_byte_q == `SFB_OP_BUF_RD_FAST)  ? sfb_pkg::SFB_CMD_BUF_RD :
    (rx_byte_q == `SFB_OP_BUF_RD_SLOW)  ? sfb_pkg::SFB_CMD_BUF_RD :
    (rx_byte_q == `SFB_OP_PAGE_RD)      ? sfb_pkg::SFB_CMD_PAGE_RD :
    (rx_byte_q == `SFB_OP_BUF_WR)       ? sfb_pkg::SFB_CMD_BUF_WR :
    (rx_byte_q == `SFB_OP_ERASE_PROG)   ? sfb_pkg::SFB_CMD_ERASE_PROG :
    (rx_byte_q == `SFB_OP_PROG)         ? sfb_pkg::SFB_CMD_PROG :
    (rx_byte_q == `SFB_OP_PAGE_ERASE)   ? sfb_pkg::SFB_CMD_PAGE_ERASE :
    (rx_byte_q == `SFB_OP_BLOCK_ERASE)  ? sfb_pkg::SFB_CMD_BLOCK_ERASE :
                                          sfb_pkg::SFB_CMD_NONE;

  assign addr_full = {addr_q, rx_byte_q};
  assign is_pg     = (cmd_q == sfb_pkg::SFB_CMD_PAGE_RD);
  assign is_rd     = is_pg || (cmd_q == sfb_pkg::SFB_CMD_BUF_RD);
  // buffer data follows one ignored byte
  assign hdr_len   = is_pg ? `SFB_HDR_PAGE_RD : `SFB_HDR_BUF_RD;
  assign ptr_now   = (idx_q == `SFB_IDX_ADDR3) ?
                     ofs_of(addr_full, p256_q) : ptr_q;
  assign do_fetch  = ev && is_rd && (idx_q >= hdr_len - 4'h2);
  // data bytes after address go to buffer
  assign do_bwr    = ev && (cmd_q == sfb_pkg::SFB_CMD_BUF_WR) &&
                     (idx_q >= `SFB_IDX_DATA);

  // frame decoder
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_q   <= sfb_pkg::SFB_CMD_NONE;
      idx_q   <= 4'h0;
      addr_q  <= 16'h0000;
      page_q  <= 10'h000;
      ptr_q   <= 9'h000;
      tx_on_q <= 1'b0;
    end else if (cs_rise) begin
      cmd_q   <= sfb_pkg::SFB_CMD_NONE;
      idx_q   <= 4'h0;
      tx_on_q <= 1'b0;
    end else if (ev) begin
      if (idx_q != `SFB_IDX_MAX) begin
        idx_q <= idx_q + 4'h1;
      end
      if (idx_q == 4'h0) begin
        cmd_q <= busy_q ? sfb_pkg::SFB_CMD_NONE : cmd_dec;
      end
      if (idx_q == `SFB_IDX_ADDR1) begin
        addr_q[15:8] <= rx_byte_q;
      end
      if (idx_q == `SFB_IDX_ADDR2) begin
        addr_q[7:0] <= rx_byte_q;
      end
      if (idx_q == `SFB_IDX_ADDR3) begin
        page_q <= page_of(addr_full, p256_q);
        ptr_q  <= ptr_now;
      end
      if (do_fetch || do_bwr) begin
        ptr_q <= ofs_next(ptr_now, p256_q);
      end
      if (do_fetch) begin
        tx_on_q <= 1'b1;
      end
    end
  end

  // read data from buffer, or from array for page reads
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend1_q   <= 1'b0;
      pend2_q   <= 1'b0;
      tx_byte_q <= 8'h00;
    end else begin
      pend1_q <= do_fetch;
      pend2_q <= pend1_q;
      if (pend1_q && !is_pg) begin
        tx_byte_q <= ram_rdata;
      end else if (pend2_q && is_pg) begin
        tx_byte_q <= arr_rdata;
      end
    end
  end

  assign ram_we   = do_bwr;
  assign ram_addr = busy_q ? cnt_q : ptr_now;

  sfb_buffer_ram #(
    .DEPTH (`SFB_BUF_DEPTH),
    .AW    (9)
  ) u_buf (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (rx_byte_q),
    .rdata_q (ram_rdata)
  );

  // self-timed operations start on chip select rise
  assign is_op = (cmd_q == sfb_pkg::SFB_CMD_ERASE_PROG) ||
                 (cmd_q == sfb_pkg::SFB_CMD_PROG) ||
                 (cmd_q == sfb_pkg::SFB_CMD_PAGE_ERASE) ||
                 (cmd_q == sfb_pkg::SFB_CMD_BLOCK_ERASE);
  assign start = cs_rise && !busy_q && is_op &&
                 (idx_q >= `SFB_IDX_DATA);

  assign tmr_load =
    (cmd_q == sfb_pkg::SFB_CMD_ERASE_PROG) ? 32'(ERASE_PROG_CYC) :
    (cmd_q == sfb_pkg::SFB_CMD_PROG)       ? 32'(PROG_CYC) :
    (cmd_q == sfb_pkg::SFB_CMD_PAGE_ERASE) ? 32'(PAGE_ERASE_CYC) :
                                             32'(BLOCK_ERASE_CYC);
  assign erase_last = (op_q == sfb_pkg::SFB_CMD_BLOCK_ERASE) ?
                      `SFB_BLOCK_PAGES : 3'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= sfb_pkg::SFB_ST_IDLE;
      op_q        <= sfb_pkg::SFB_CMD_NONE;
      op_page_q   <= 10'h000;
      cnt_q       <= 9'h000;
      tmr_q       <= 32'h0000_0000;
      busy_q      <= 1'b0;
      arr_rd_q    <= 1'b0;
      arr_wr_q    <= 1'b0;
      arr_erase_q <= 1'b0;
      arr_page_q  <= 10'h000;
      arr_col_q   <= 9'h000;
      arr_wdata_q <= 8'h00;
    end else begin
      arr_rd_q    <= 1'b0;
      arr_wr_q    <= 1'b0;
      arr_erase_q <= 1'b0;
      if (tmr_q != 32'h0000_0000) begin
        tmr_q <= tmr_q - 32'h0000_0001;
      end
      unique case (state_q)
        sfb_pkg::SFB_ST_IDLE: begin
          if (do_fetch && is_pg) begin
            arr_rd_q   <= 1'b1;
            arr_page_q <= page_q;
            arr_col_q  <= ptr_now;
          end
          if (start) begin
            busy_q <= 1'b1;
            op_q   <= cmd_q;
            tmr_q  <= tmr_load;
            cnt_q  <= 9'h000;
            // block uses upper seven page bits
            op_page_q <= (cmd_q == sfb_pkg::SFB_CMD_BLOCK_ERASE) ?
                         {page_q[9:3], 3'h0} : page_q;
            state_q <= (cmd_q == sfb_pkg::SFB_CMD_PROG) ?
                       sfb_pkg::SFB_ST_PROG_RD : sfb_pkg::SFB_ST_ERASE;
          end
        end
        sfb_pkg::SFB_ST_ERASE: begin
          arr_erase_q <= 1'b1;
          arr_page_q  <= op_page_q | {7'h00, cnt_q[2:0]};
          if (cnt_q[2:0] == erase_last) begin
            cnt_q   <= 9'h000;
            state_q <= (op_q == sfb_pkg::SFB_CMD_ERASE_PROG) ?
                       sfb_pkg::SFB_ST_PROG_RD : sfb_pkg::SFB_ST_WAIT;
          end else begin
            cnt_q <= cnt_q + 9'h001;
          end
        end
        sfb_pkg::SFB_ST_PROG_RD: begin
          state_q <= sfb_pkg::SFB_ST_PROG_WR;
        end
        sfb_pkg::SFB_ST_PROG_WR: begin
          arr_wr_q    <= 1'b1;
          arr_page_q  <= op_page_q;
          arr_col_q   <= cnt_q;
          arr_wdata_q <= ram_rdata;
          if (cnt_q == ofs_last(p256_q)) begin
            state_q <= sfb_pkg::SFB_ST_WAIT;
          end else begin
            cnt_q   <= cnt_q + 9'h001;
            state_q <= sfb_pkg::SFB_ST_PROG_RD;
          end
        end
        sfb_pkg::SFB_ST_WAIT: begin
          if (tmr_q == 32'h0000_0000) begin
            busy_q  <= 1'b0;
            cnt_q   <= 9'h000;
            state_q <= sfb_pkg::SFB_ST_IDLE;
          end
        end
        default: begin
          state_q <= sfb_pkg::SFB_ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- sfb_params.svh
// constants of the serial flash buffer, program and erase sequencer
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

// opcodes
`define SFB_OP_BUF_RD_FAST  8'hD4
`define SFB_OP_BUF_RD_SLOW  8'hD1
`define SFB_OP_PAGE_RD      8'hD2
`define SFB_OP_BUF_WR       8'h84
`define SFB_OP_ERASE_PROG   8'h83
`define SFB_OP_PROG         8'h88
`define SFB_OP_PAGE_ERASE   8'h81
`define SFB_OP_BLOCK_ERASE  8'h50

// buffer and page geometry
`define SFB_BUF_DEPTH       264
`define SFB_LAST_264        9'h107
`define SFB_LAST_256        9'h0FF
`define SFB_BLOCK_PAGES     3'h7

// byte positions in a frame
`define SFB_IDX_ADDR1       4'h1
`define SFB_IDX_ADDR2       4'h2
`define SFB_IDX_ADDR3       4'h3
`define SFB_IDX_DATA        4'h4
`define SFB_IDX_MAX         4'hF
`define SFB_HDR_BUF_RD      4'h5
`define SFB_HDR_PAGE_RD     4'h8

// self-timed operation times (microseconds) and clock period
`define SFB_CLK_PERIOD_NS   8
`define SFB_T_ERASE_PROG_US 40000
`define SFB_T_PROG_US       4000
`define SFB_T_PAGE_ERASE_US 35000
`define SFB_T_BLOCK_ERASE_US 100000

`endif

//--- sfb_pkg.sv
// types of the serial flash buffer, program and erase sequencer
package sfb_pkg;

  typedef enum logic [2:0] {
    SFB_CMD_NONE,
    SFB_CMD_BUF_RD,
    SFB_CMD_PAGE_RD,
    SFB_CMD_BUF_WR,
    SFB_CMD_ERASE_PROG,
    SFB_CMD_PROG,
    SFB_CMD_PAGE_ERASE,
    SFB_CMD_BLOCK_ERASE
  } sfb_cmd_e;

  typedef enum logic [2:0] {
    SFB_ST_IDLE,
    SFB_ST_ERASE,
    SFB_ST_PROG_RD,
    SFB_ST_PROG_WR,
    SFB_ST_WAIT
  } sfb_state_e;

endpackage

//--- sfb_buffer_ram.sv
// sram data buffer with registered read data
`timescale 1ns/100ps
module sfb_buffer_ram #(
  parameter int DEPTH = 264,
  parameter int AW    = 9
) (
  // clock
  input  wire logic          clk_sys,
  // access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_q
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule

//--- sfb_flash_seq_props.sv
// assertions on the ports of the flash sequencer
`timescale 1ns/100ps
module sfb_flash_seq_props (
  // system
  input wire logic       clk_sys,
  input wire logic       rst,
  // link
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       so_q,
  input wire logic       so_oe_q,
  input wire logic       page_256,
  // array and status
  input wire logic       arr_rd_q,
  input wire logic       arr_wr_q,
  input wire logic       arr_erase_q,
  input wire logic [9:0] arr_page_q,
  input wire logic [8:0] arr_col_q,
  input wire logic [7:0] arr_wdata_q,
  input wire logic [7:0] arr_rdata,
  input wire logic       busy_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_oe_cs_high: assert property (cs_n |-> !so_oe_q)
    else $error("output driven while deselected");
  chk_rd_no_buf: assert property (arr_rd_q |-> !busy_q && !arr_wr_q)
    else $error("page read during program");
  chk_wr_busy: assert property (arr_wr_q |-> busy_q && !arr_erase_q)
    else $error("program outside busy");
  chk_erase_busy: assert property (arr_erase_q |-> busy_q)
    else $error("erase outside busy");
  chk_wr_gap: assert property (arr_wr_q |=> !arr_wr_q)
    else $error("program pulses back to back");
  chk_busy_cause: assert property ($rose(busy_q) |-> cs_n)
    else $error("busy began inside a frame");
  chk_busy_hold: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("busy dropped early");
  chk_block_step: assert property (arr_erase_q ##1 arr_erase_q |->
    arr_page_q == $past(arr_page_q) + 10'h001)
    else $error("block erase pages not consecutive");
  chk_block_count: assert property (arr_erase_q [*8] |=> !arr_erase_q)
    else $error("more than eight erase pulses");

  cover property ($rose(so_oe_q));
  cover property (arr_erase_q [*8]);
  cover property (arr_wr_q ##2 arr_wr_q);
endmodule

bind sfb_flash_seq sfb_flash_seq_props i_sfb_flash_seq_props (
  .clk_sys, .rst, .sck, .cs_n, .si, .so_q, .so_oe_q, .page_256,
  .arr_rd_q, .arr_wr_q, .arr_erase_q, .arr_page_q, .arr_col_q,
  .arr_wdata_q, .arr_rdata, .busy_q
);

//--- sfb_host_model.sv
// serial host model driving the flash link in mode 0
`timescale 1ns/100ps
module sfb_host_model (
  // link out
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  // link in
  input  wire logic so_q,
  input  wire logic so_oe_q
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // select held low for the frame
  task automatic start();
    #3 cs_n = 1'b0;
    #24;
  endtask
  // one byte msb first, sck 48 ns
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #24 sck = 1'b1;
      rx[i] = so_oe_q ? so_q : 1'bx;
      #24 sck = 1'b0;
    end
  endtask
  task automatic stop();
    #48 cs_n = 1'b1;
    si = ~si;
    #48;
  endtask
endmodule

//--- testbench.sv
// testbench of the flash sequencer with host and array models
`timescale 1ns/100ps
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       page_256 = 1'b0;
  logic [7:0] arr_rdata = 8'h00;
  logic       sck, cs_n, si, so_q, so_oe_q, busy_q;
  logic       arr_rd_q, arr_wr_q, arr_erase_q;
  logic [9:0] arr_page_q, exp_pg;
  logic [8:0] arr_col_q;
  logic [7:0] arr_wdata_q;
  logic [7:0] sbuf [0:263];
  logic [7:0] nq [$];
  int         err_total, checked, n_er, n_wr;

  always #4 clk_sys = ~clk_sys;

  sfb_flash_seq #(.ERASE_PROG_CYC(600), .PROG_CYC(600),
    .PAGE_ERASE_CYC(600), .BLOCK_ERASE_CYC(600)) i_sfb_flash_seq (
    .clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .so_q(so_q), .so_oe_q(so_oe_q), .page_256(page_256),
    .arr_rd_q(arr_rd_q), .arr_wr_q(arr_wr_q), .arr_erase_q(arr_erase_q),
    .arr_page_q(arr_page_q), .arr_col_q(arr_col_q),
    .arr_wdata_q(arr_wdata_q), .arr_rdata(arr_rdata), .busy_q(busy_q));

  sfb_host_model i_sfb_host_model (.sck(sck), .cs_n(cs_n), .si(si),
    .so_q(so_q), .so_oe_q(so_oe_q));

  function automatic logic [7:0] pat(input logic [9:0] p, logic [8:0] c);
    return p[7:0] ^ c[7:0] ^ {7'h00, c[8]} ^ 8'h5a;
  endfunction
  function automatic logic [8:0] nxt(input logic [8:0] o, int i,
                                     logic [8:0] l);
    int v;
    v = o + i;
    return 9'(v > l ? v - l - 1 : v);
  endfunction
  function automatic logic [23:0] pa(input int m, logic [9:0] p,
                                     logic [8:0] c);
    return m ? {6'($urandom), p, c[7:0]} : {5'($urandom), p, c};
  endfunction
  function automatic logic [23:0] ba(input int m, logic [8:0] o);
    return {15'($urandom), m ? {1'($urandom), o[7:0]} : o};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // array model, data valid the cycle after the read pulse
  always @(posedge clk_sys) begin
    arr_rdata <= pat(arr_page_q, arr_col_q);
    if (arr_rd_q) begin
      chk(arr_page_q, exp_pg);
    end
    if (arr_erase_q) begin
      chk(arr_page_q, exp_pg + 10'(n_er));
      chk(16'(n_wr), 16'h0000);
      n_er++;
    end
    if (arr_wr_q) begin
      chk(arr_page_q, exp_pg);
      chk(arr_wdata_q, sbuf[arr_col_q]);
      n_wr++;
    end
  end

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (12) @(posedge clk_sys);
    while (busy_q !== 1'b0 && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 5000) begin
      err_total++;
      $display("mismatch %0t busy never ended", $time);
      tally_and_finish();
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a,
                       input int nd, input logic rd, input logic [7:0] d[$]);
    logic [7:0] r;
    i_sfb_host_model.start();
    i_sfb_host_model.xbyte(op, r);
    for (int i = 2; i >= 0; i--) i_sfb_host_model.xbyte(a[i*8+:8], r);
    repeat (nd) i_sfb_host_model.xbyte(8'($urandom), r);
    foreach (d[i]) begin
      i_sfb_host_model.xbyte(rd ? 8'($urandom) : d[i], r);
      if (rd) chk(r, d[i]);
    end
    i_sfb_host_model.stop();
    chk(so_oe_q, 1'b0);
    wait_idle();
  endtask

  initial begin
    logic [7:0] q[$];
    logic [8:0] last, off;
    logic [9:0] pg;
    void'($urandom(32'hd5e996e2));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    for (int m = 0; m < 2; m++) begin
      page_256 <= m[0];
      repeat (4) @(posedge clk_sys);
      last = m ? 9'h0ff : 9'h107;
      off = last - 9'h001;
      q = {};
      for (int i = 0; i <= last; i++) q.push_back(8'($urandom));
      foreach (q[i]) sbuf[i] = q[i];
      frame(8'h84, ba(m, 9'h000), 0, 1'b0, q);
      q = {};
      for (int i = 0; i < 4; i++) q.push_back(8'($urandom));
      foreach (q[i]) sbuf[nxt(off, i, last)] = q[i];
      // write near the end wraps to zero
      frame(8'h84, ba(m, off), 0, 1'b0, q);
      pg = 10'($urandom);
      exp_pg = pg;
      // page read wraps within its page
      frame(8'hd2, pa(m, pg, last), 4, 1'b1,
            {pat(pg, last), pat(pg, 9'h000), pat(pg, 9'h001)});
      frame(m ? 8'hd1 : 8'hd4, ba(m, off), 1, 1'b1, q);
      frame(m ? 8'hd4 : 8'hd1, ba(m, last), 1, 1'b1,
            {sbuf[last], sbuf[0]});
      exp_pg = pg;
      n_er = 0;
      n_wr = 0;
      frame(8'h81, pa(m, pg, 9'($urandom)), 0, 1'b0, nq);
      chk(16'(n_er), 16'h0001);
      n_er = 0;
      frame(8'h88, pa(m, pg, 9'($urandom)), 0, 1'b0, nq);
      chk(16'(n_wr), 16'(last) + 16'h0001);
      chk(16'(n_er), 16'h0000);
      n_wr = 0;
      frame(8'h83, pa(m, pg, 9'($urandom)), 0, 1'b0, nq);
      chk(16'(n_er), 16'h0001);
      chk(16'(n_wr), 16'(last) + 16'h0001);
      exp_pg = {pg[9:3], 3'h0};
      n_er = 0;
      n_wr = 0;
      frame(8'h50, pa(m, pg, 9'($urandom)), 0, 1'b0, nq);
      chk(16'(n_er), 16'h0008);
    end
    tally_and_finish();
  end
endmodule
